//--- ssdc_pkg.sv
// constants, register map and image builder for the superspeed capability
// descriptor block; assumes a single 100 MHz clock and little-endian fields.
//
// Behaviour
// - every superspeed device provides this capability
// - stand-alone requests for it are refused
// - bytes 0..2: length, devcap type, cap code
// - capability code is 03H
// - attribute bit one means feature supported
// - attribute bit 1 set when LTM capable
// - attribute bits 0 and 7:2 read zero
// - speeds field at offset 4, bit 0 low
// - offset 6 holds lowest full-function speed bit
// - offset 7 U1 exit latency, max 0AH
// - one U1 latency for every port
// - offset 8 U2 exit latency, max 07FFH
// - one U2 latency for every port
// - hub latencies valid upstream and downstream
package ssdc_pkg;
    localparam int AXI_ADDR_W = 8;
    localparam int DESC_BYTES = 10;
    localparam int DESC_W = 80;
    localparam logic [7:0] DESC_LEN = 8'h0A;
    // descriptor type for device capabilities; plain default
    localparam logic [7:0] DESC_TYPE_DEVCAP = 8'h10;
    localparam logic [7:0] CAP_SUPERSPEED = 8'h03;

    localparam logic [3:0] OFF_LEN = 4'h0;
    localparam logic [3:0] OFF_TYPE = 4'h1;
    localparam logic [3:0] OFF_CAP = 4'h2;
    localparam logic [3:0] OFF_ATTR = 4'h3;
    localparam logic [3:0] OFF_SPEED_LO = 4'h4;
    localparam logic [3:0] OFF_SPEED_HI = 4'h5;
    localparam logic [3:0] OFF_FUNC = 4'h6;
    localparam logic [3:0] OFF_U1 = 4'h7;
    localparam logic [3:0] OFF_U2_LO = 4'h8;
    localparam logic [3:0] OFF_U2_HI = 4'h9;

    localparam int ATTR_LTM_BIT = 1;
    localparam int SPD_W = 4;
    localparam logic [7:0] U1_MAX = 8'h0A;
    localparam logic [15:0] U2_MAX = 16'h07FF;

    localparam logic RST_LTM = 1'b0;
    localparam logic [3:0] RST_SPEEDS = 4'hE;
    localparam logic [7:0] RST_FUNC = 8'h01;
    localparam logic [7:0] RST_U1 = 8'h0A;
    localparam logic [15:0] RST_U2 = 16'h07FF;

    localparam logic [7:0] REG_ATTR = 8'h00;
    localparam logic [7:0] REG_SPEED = 8'h04;
    localparam logic [7:0] REG_FUNC = 8'h08;
    localparam logic [7:0] REG_U1 = 8'h0C;
    localparam logic [7:0] REG_U2 = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    localparam int STAT_SERVED_LSB = 0;
    localparam int STAT_REFUSED_LSB = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // multi-byte fields go out least significant byte first
    function automatic logic [DESC_W-1:0] descImage(
        input logic ltm,
        input logic [3:0] speeds,
        input logic [7:0] func,
        input logic [7:0] u1,
        input logic [15:0] u2
    );
        descImage = {u2[15:8], u2[7:0], u1, func, 8'h00, {4'h0, speeds},
                     {6'h00, ltm, 1'b0}, CAP_SUPERSPEED, DESC_TYPE_DEVCAP,
                     DESC_LEN};
    endfunction
endpackage

//--- ssdc_mem_if.sv
// carrier between the register side and the descriptor byte store;
// assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ssdc_mem_if;
    import ssdc_pkg::*;
    logic wrEn;
    logic [DESC_W-1:0] wrImage;
    logic rdEn;
    logic [3:0] rdAddr;
    logic [7:0] rdData;
    modport owner (output wrEn, output wrImage, output rdEn, output rdAddr,
                   input rdData);
    modport store (input wrEn, input wrImage, input rdEn, input rdAddr,
                   output rdData);
endinterface

//--- ssdc_desc_mem.sv
// byte store holding the ten-byte descriptor image, registered read;
// assumes the owner rewrites the whole image whenever a field changes.
`timescale 1ns/1ps
module ssdc_desc_mem (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    ssdc_mem_if.store mem
);
    import ssdc_pkg::*;

    typedef struct packed {
        logic [DESC_W-1:0] image;
        logic [7:0] rdData;
    } ssdc_mem_state_t;

    ssdc_mem_state_t r;
    ssdc_mem_state_t next_r;

    function automatic logic [7:0] byteAt(input logic [DESC_W-1:0] img,
                                          input logic [3:0] addr);
        if ({4'h0, addr} < DESC_LEN) begin
            byteAt = img[{addr, 3'b000} +: 8];
        end else begin
            byteAt = 8'h00;
        end
    endfunction

    always_comb begin
        next_r = r;
        if (mem.wrEn) begin
            next_r.image = mem.wrImage;
        end
        // read sees the image before a same-cycle write
        if (mem.rdEn) begin
            next_r.rdData = byteAt(r.image, mem.rdAddr);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            // descriptor present from reset on
            r <= {descImage(RST_LTM, RST_SPEEDS, RST_FUNC, RST_U1, RST_U2),
                  8'h00};
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign mem.rdData = r.rdData;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    mem_length_byte_a: assert property (
        $past(ce) && $past(mem.rdEn) && $past(mem.rdAddr) == OFF_LEN
        |-> mem.rdData == DESC_LEN)
        else $error("length byte wrong");
endmodule

//--- ssdc_top.sv
// superspeed capability descriptor source with axi4-lite configuration;
// assumes the bos assembler drives the byte port synchronously to clk.
`timescale 1ns/1ps
module ssdc_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [ssdc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ssdc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic descReq,
    input wire logic descInBos,
    input wire logic [3:0] descOffset,
    output logic descValid,
    output logic descRefused,
    output logic descLast,
    output logic [7:0] descData
);
    import ssdc_pkg::*;

    typedef struct packed {
        logic awHeld;
        logic [AXI_ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ltm;
        logic [3:0] speeds;
        logic [7:0] func;
        logic [7:0] u1;
        logic [15:0] u2;
        logic [7:0] servedCnt;
        logic [7:0] refusedCnt;
        logic pendValid;
        logic pendRefused;
        logic [3:0] pendOff;
        logic rdValid;
        logic rdRefused;
        logic rdLast;
        logic [3:0] rdOff;
        logic [7:0] rdData;
    } ssdc_top_state_t;

    ssdc_top_state_t r;
    ssdc_top_state_t next_r;
    ssdc_mem_if memBus ();
    logic byteOk;
    logic doWrite;
    logic [31:0] merged;

    ssdc_desc_mem descStore (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .mem(memBus.store)
    );

    // byte-lane merge of a write onto the current register word
    function automatic logic [31:0] mergeWord(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            old[8*i +: 8] = strb[i] ? data[8*i +: 8] : old[8*i +: 8];
        end
        mergeWord = old;
    endfunction

    // lowest full-function speed must name a supported speed bit
    function automatic logic funcOk(input logic [3:0] speeds,
                                    input logic [7:0] func);
        funcOk = (func < 8'(SPD_W)) && speeds[func[1:0]];
    endfunction

    function automatic logic [7:0] sat8(input logic [7:0] v);
        sat8 = (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    always_comb begin
        next_r = r;
        merged = 32'h0000_0000;
        doWrite = 1'b0;

        // stand-alone fetches never reach the store
        byteOk = descInBos && ({4'h0, descOffset} < DESC_LEN);
        memBus.rdEn = descReq && byteOk;
        memBus.rdAddr = descOffset;
        next_r.pendValid = descReq;
        next_r.pendRefused = descReq && !byteOk;
        next_r.pendOff = descOffset;

        next_r.rdValid = r.pendValid;
        next_r.rdRefused = r.pendRefused;
        next_r.rdOff = r.pendOff;
        next_r.rdData = (r.pendValid && !r.pendRefused) ? memBus.rdData
                                                        : 8'h00;
        next_r.rdLast = r.pendValid && !r.pendRefused &&
                        r.pendOff == OFF_U2_HI;

        // write side: address and data taken in either order
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
            next_r.awready = 1'b1;
            next_r.wready = 1'b1;
        end
        if (s_axi_awvalid && r.awready) begin
            next_r.awHeld = 1'b1;
            next_r.awAddr = s_axi_awaddr;
            next_r.awready = 1'b0;
        end
        if (s_axi_wvalid && r.wready) begin
            next_r.wHeld = 1'b1;
            next_r.wData = s_axi_wdata;
            next_r.wStrb = s_axi_wstrb;
            next_r.wready = 1'b0;
        end

        if (r.awHeld && r.wHeld && !r.bvalid) begin
            doWrite = 1'b1;
            next_r.awHeld = 1'b0;
            next_r.wHeld = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = RESP_OKAY;
            // a rejected value leaves the field untouched, so the
            // descriptor never carries a reserved code
            case (r.awAddr)
                REG_ATTR: begin
                    merged = mergeWord({30'h0, r.ltm, 1'b0}, r.wData,
                                       r.wStrb);
                    // only the capability bit is writable
                    next_r.ltm = merged[ATTR_LTM_BIT];
                end
                REG_SPEED: begin
                    merged = mergeWord({28'h0, r.speeds}, r.wData,
                                       r.wStrb);
                    // upper speed bits dropped
                    if (funcOk(merged[3:0], r.func)) begin
                        next_r.speeds = merged[3:0];
                    end else begin
                        next_r.bresp = RESP_SLVERR;
                    end
                end
                REG_FUNC: begin
                    merged = mergeWord({24'h0, r.func}, r.wData, r.wStrb);
                    if (funcOk(r.speeds, merged[7:0])) begin
                        next_r.func = merged[7:0];
                    end else begin
                        next_r.bresp = RESP_SLVERR;
                    end
                end
                REG_U1: begin
                    merged = mergeWord({24'h0, r.u1}, r.wData, r.wStrb);
                    // one per-port figure, good for every hub port
                    if (merged[7:0] <= U1_MAX) begin
                        next_r.u1 = merged[7:0];
                    end else begin
                        next_r.bresp = RESP_SLVERR;
                    end
                end
                REG_U2: begin
                    merged = mergeWord({16'h0, r.u2}, r.wData, r.wStrb);
                    // one figure shared by all ports
                    if (merged[15:0] <= U2_MAX) begin
                        next_r.u2 = merged[15:0];
                    end else begin
                        next_r.bresp = RESP_SLVERR;
                    end
                end
                REG_STAT: begin
                    next_r.servedCnt = 8'h00;
                    next_r.refusedCnt = 8'h00;
                end
                default: begin
                    next_r.bresp = RESP_DECERR;
                end
            endcase
        end

        // counting after the clear lets a same-cycle event survive it
        if (r.rdLast) begin
            next_r.servedCnt = sat8(next_r.servedCnt);
        end
        if (r.rdValid && r.rdRefused) begin
            next_r.refusedCnt = sat8(next_r.refusedCnt);
        end

        // store follows the fields at the same edge
        memBus.wrEn = doWrite;
        memBus.wrImage = descImage(next_r.ltm, next_r.speeds, next_r.func,
                                   next_r.u1, next_r.u2);

        // read side
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
            next_r.arready = 1'b1;
        end
        if (s_axi_arvalid && r.arready) begin
            next_r.arready = 1'b0;
            next_r.rvalid = 1'b1;
            next_r.rresp = RESP_OKAY;
            case (s_axi_araddr)
                REG_ATTR: next_r.rdata = {30'h0, r.ltm, 1'b0};
                REG_SPEED: next_r.rdata = {28'h0, r.speeds};
                REG_FUNC: next_r.rdata = {24'h0, r.func};
                REG_U1: next_r.rdata = {24'h0, r.u1};
                REG_U2: next_r.rdata = {16'h0, r.u2};
                REG_STAT: next_r.rdata = {16'h0, r.refusedCnt,
                                          r.servedCnt};
                default: begin
                    next_r.rdata = 32'h0000_0000;
                    next_r.rresp = RESP_DECERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= '0;
            r.awready <= 1'b1;
            r.wready <= 1'b1;
            r.arready <= 1'b1;
            r.ltm <= RST_LTM;
            r.speeds <= RST_SPEEDS;
            r.func <= RST_FUNC;
            r.u1 <= RST_U1;
            r.u2 <= RST_U2;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign descValid = r.rdValid;
    assign descRefused = r.rdRefused;
    assign descLast = r.rdLast;
    assign descData = r.rdData;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    header_length_a: assert property (
        r.rdValid && !r.rdRefused && r.rdOff == OFF_LEN
        |-> r.rdData == DESC_LEN)
        else $error("length byte wrong");

    header_type_a: assert property (
        r.rdValid && !r.rdRefused && r.rdOff == OFF_TYPE
        |-> r.rdData == DESC_TYPE_DEVCAP)
        else $error("descriptor type byte wrong");

    capability_code_a: assert property (
        r.rdValid && !r.rdRefused && r.rdOff == OFF_CAP
        |-> r.rdData == CAP_SUPERSPEED)
        else $error("capability code wrong");

    standalone_refused_a: assert property (
        ce && descReq && !descInBos ##1 ce
        |=> r.rdValid && r.rdRefused && r.rdData == 8'h00)
        else $error("stand-alone request served");

    attr_reserved_a: assert property (
        r.rdValid && !r.rdRefused && r.rdOff == OFF_ATTR
        |-> r.rdData[7:2] == 6'h00 && !r.rdData[0])
        else $error("reserved attribute bit set");

    ltm_bit_a: assert property (
        r.rdValid && !r.rdRefused && r.rdOff == OFF_ATTR &&
        $past(ce) && $past(ce, 2) && !$past(doWrite, 2)
        |-> r.rdData[ATTR_LTM_BIT] == $past(r.ltm, 2))
        else $error("capability bit disagrees with setting");

    speed_upper_a: assert property (
        r.rdValid && !r.rdRefused &&
        (r.rdOff == OFF_SPEED_HI || r.rdOff == OFF_SPEED_LO)
        |-> r.rdData[7:4] == 4'h0 &&
            (r.rdOff == OFF_SPEED_LO || r.rdData == 8'h00))
        else $error("unassigned speed bit set");

    func_supported_a: assert property (
        r.func < 8'(SPD_W) && r.speeds[r.func[1:0]])
        else $error("function speed not supported");

    u1_range_a: assert property (
        r.u1 <= U1_MAX)
        else $error("u1 latency reserved");

    u2_range_a: assert property (
        r.u2 <= U2_MAX)
        else $error("u2 latency reserved");

    last_byte_a: assert property (
        r.rdLast |-> r.rdValid && r.rdOff == OFF_U2_HI &&
                     r.rdData == $past(r.u2[15:8], 2) ||
                     $past(doWrite, 2) || !$past(ce, 2))
        else $error("last byte wrong");

    bresp_hold_a: assert property (
        ce && r.bvalid && !s_axi_bready |=> r.bvalid && $stable(r.bresp))
        else $error("write answer dropped");
endmodule

//--- ssdc_host_model.sv
// host model that walks the descriptor byte port and gathers the bytes;
// assumes one answer per request, returned in request order.
`timescale 1ns/1ps
module ssdc_host_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic fetch,
    input wire logic inBos,
    input wire logic slow,
    input wire logic extra,
    input wire logic descValid,
    input wire logic descRefused,
    input wire logic [7:0] descData,
    output logic descReq,
    output logic descInBos,
    output logic [3:0] descOffset,
    output logic [79:0] image,
    output logic [4:0] refusedCnt,
    output logic busy
);
    logic [4:0] txIdx;
    logic [4:0] rxIdx;
    logic [1:0] gap;
    always @(posedge clk) begin
        descReq <= 1'b0;
        // idle qualifiers keep moving so a stale value never looks valid
        descOffset <= ~descOffset;
        descInBos <= ~descInBos;
        if (!rstn) begin
            busy <= 1'b0;
            descOffset <= 4'h0;
            descInBos <= 1'b0;
        end else if (fetch && !busy) begin
            busy <= 1'b1;
            txIdx <= 5'h00;
            rxIdx <= 5'h00;
            gap <= 2'h0;
            refusedCnt <= 5'h00;
            image <= {80{1'b1}};
        end else if (busy) begin
            if (txIdx < (extra ? 5'h10 : 5'h0A) && gap == 2'h0) begin
                descReq <= 1'b1;
                descOffset <= txIdx[3:0];
                // whole set is fetched inside the bos read unless told not to
                descInBos <= inBos;
                txIdx <= txIdx + 5'h01;
                gap <= slow ? 2'h2 : 2'h0;
            end else if (gap != 2'h0) begin
                gap <= gap - 2'h1;
            end
            if (descValid) begin
                if (rxIdx < 5'h0A) begin
                    image[rxIdx*8 +: 8] <= descData;
                end
                refusedCnt <= refusedCnt + 5'(descRefused);
                rxIdx <= rxIdx + 5'h01;
                if (rxIdx == (extra ? 5'h0F : 5'h09)) begin
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule

//--- tb_top.sv
// self-checking bench for the capability descriptor source;
// assumes the host model drives the byte port and ce stays high.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin \
    errTotal++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    import ssdc_pkg::*;
    logic clk;
    logic rstn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic fetch = 1'b0, inBos = 1'b0, slow = 1'b0, extra = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, busy;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic descReq, descInBos, descValid, descRefused, descLast;
    logic [3:0] descOffset;
    logic [7:0] descData;
    logic [79:0] image;
    logic [4:0] refusedCnt;
    logic ltm = 1'b0;
    logic [3:0] spd = 4'hE;
    logic [7:0] fn = 8'h01, u1 = 8'h0A;
    logic [15:0] u2 = 16'h07FF;
    logic [31:0] rd;
    logic [1:0] r;
    int served = 0, refused = 0, errTotal = 0, nCompared = 0, seedVal;
    int lastCnt = 0;

    ssdc_top uut (.clk(clk), .rstn(rstn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .descReq(descReq),
        .descInBos(descInBos), .descOffset(descOffset),
        .descValid(descValid), .descRefused(descRefused),
        .descLast(descLast),
        .descData(descData));
    ssdc_host_model host (.clk(clk), .rstn(rstn), .fetch(fetch),
        .inBos(inBos), .slow(slow), .extra(extra), .descValid(descValid),
        .descRefused(descRefused), .descData(descData), .descReq(descReq),
        .descInBos(descInBos), .descOffset(descOffset), .image(image),
        .refusedCnt(refusedCnt), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // end-of-descriptor pulses, one per served byte 9
    always @(posedge clk) begin
        if (descLast === 1'b1) lastCnt++;
    end

    // fields go out low byte first, speeds and u2 as two bytes each
    function automatic logic [79:0] expImage();
        return {u2, u1, fn, 8'h00, 4'h0, spd, 6'h00, ltm, 1'b0, 8'h03,
                DESC_TYPE_DEVCAP, 8'h0A};
    endfunction

    function automatic logic legal(input logic [7:0] a, input logic [31:0] d);
        case (a)
            REG_SPEED: return d[fn[1:0]];
            REG_FUNC: return d[7:0] < 8'h04 && spd[d[1:0]];
            REG_U1: return d[7:0] <= 8'h0A;
            REG_U2: return d[15:0] <= 16'h07FF;
            default: return 1'b1;
        endcase
    endfunction

    task automatic give_verdict();
        $display("compared %0d, errors %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic regCheck(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] rs;
        axr(a, d, rs);
        `CHK("rdata", e, d);
        `CHK("rresp", RESP_OKAY, rs);
    endtask

    task automatic cfgWrite(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] rs;
        logic ok;
        ok = legal(a, d);
        axw(a, d, 4'hF, rs);
        `CHK("bresp", ok ? RESP_OKAY : RESP_SLVERR, rs);
        if (ok) begin
            case (a)
                REG_ATTR: ltm = d[1];
                REG_SPEED: spd = d[3:0];
                REG_FUNC: fn = d[7:0];
                REG_U1: u1 = d[7:0];
                default: u2 = d[15:0];
            endcase
        end
    endtask

    task automatic fetchCheck(input logic b, input logic s, input logic x);
        int rf;
        rf = b ? (x ? 6 : 0) : (x ? 16 : 10);
        @(posedge clk);
        inBos <= b;
        slow <= s;
        extra <= x;
        fetch <= 1'b1;
        @(posedge clk);
        fetch <= 1'b0;
        do begin
            @(negedge clk);
        end while (busy);
        `CHK("image", b ? expImage() : 80'h0, image);
        `CHK("refused", 5'(rf), refusedCnt);
        served += b;
        refused += rf;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        give_verdict();
    end

    initial begin
        seedVal = $urandom(32'h28FA);
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        regCheck(REG_ATTR, 32'h0);
        regCheck(REG_SPEED, 32'hE);
        regCheck(REG_FUNC, 32'h1);
        regCheck(REG_U1, 32'h0A);
        regCheck(REG_U2, 32'h07FF);
        fetchCheck(1'b1, 1'b0, 1'b0);
        fetchCheck(1'b0, 1'b1, 1'b0);
        fetchCheck(1'b1, 1'b1, 1'b1);
        // boundary values of u1, speeds and func, legal and reserved; u2 gets only a reserved one
        cfgWrite(REG_U1, 32'h0B);
        cfgWrite(REG_U1, 32'h00);
        cfgWrite(REG_U2, 32'h0800);
        cfgWrite(REG_FUNC, 32'h0);
        cfgWrite(REG_SPEED, 32'hF);
        cfgWrite(REG_FUNC, 32'h0);
        cfgWrite(REG_SPEED, 32'hE);
        cfgWrite(REG_FUNC, 32'h4);
        cfgWrite(REG_ATTR, 32'h2);
        fetchCheck(1'b1, 1'b0, 1'b0);
        // byte lanes merge onto the current value before the range check
        cfgWrite(REG_U2, 32'h0123);
        axw(REG_U2, 32'hFFFF_FF55, 4'h1, r);
        `CHK("bresp", RESP_OKAY, r);
        u2 = 16'h0155;
        axw(REG_U2, 32'hFFFF_FFFF, 4'h2, r);
        `CHK("bresp", RESP_SLVERR, r);
        regCheck(REG_U2, 32'h0155);
        axw(8'h18, 32'h1, 4'hF, r);
        `CHK("bresp", RESP_DECERR, r);
        axr(8'h18, rd, r);
        `CHK("rresp", RESP_DECERR, r);
        `CHK("rdata", 32'h0, rd);
        axr(8'h02, rd, r);
        `CHK("rresp", RESP_DECERR, r);
        for (int i = 0; i < 12; i++) begin
            cfgWrite(REG_SPEED, {28'h0, 4'($urandom)});
            cfgWrite(REG_FUNC, 32'($urandom_range(4, 0)));
            cfgWrite(REG_U1, 32'($urandom_range(12, 0)));
            cfgWrite(REG_U2, 32'($urandom_range(2304, 2000)));
            cfgWrite(REG_ATTR, {30'h0, 1'($urandom), 1'b0});
            fetchCheck(1'($urandom), 1'($urandom), 1'($urandom));
        end
        regCheck(REG_ATTR, {30'h0, ltm, 1'b0});
        regCheck(REG_SPEED, {28'h0, spd});
        regCheck(REG_FUNC, {24'h0, fn});
        regCheck(REG_U1, {24'h0, u1});
        regCheck(REG_U2, {16'h0, u2});
        `CHK("descLast", served, lastCnt);
        regCheck(REG_STAT, {16'h0, 8'(refused > 255 ? 255 : refused),
                 8'(served)});
        axw(REG_STAT, 32'h0, 4'hF, r);
        `CHK("bresp", RESP_OKAY, r);
        regCheck(REG_STAT, 32'h0);
        give_verdict();
    end
endmodule
